// ===== hdl/adcc_pkg.sv
// Package of register map, fields and timing for the converter control block
// Summary of operation
// - Input select 1000 routes the converter input to the temperature sensor.
// - Reference 00 external pin, 01 analog supply, 10 reserved, 11 internal 1.1 V.
// - Reference and input changes during a conversion apply after it completes.
// - Left align bit selects result alignment and acts immediately.
// - Bit 4 of the input and reference register always reads zero.
// - Input codes: 0-7 external, 8 sensor, 14 bandgap, 15 ground, others reserved.
// - Enable one turns the converter on; zero turns it off and aborts.
// - First conversion after enabling takes 25 converter clocks, others 13.
// - Start bit reads one while converting; writing zero does nothing.
// - With auto trigger on, a rising trigger edge starts a conversion.
// - Done flag sets when a conversion completes, even when a held result is not updated.
// - Done flag clears on interrupt vector taken or on writing one.
// - Interrupt is raised while done flag, its enable and global enable are one.
// - Divider select 0,1 give 2, then 4 to 128 in powers of two.
// - After low result byte read, result holds until high byte read.
// - Trigger source zero is free running; switching to it triggers nothing.
package adcc_pkg;
	// Word indexes on the bus; byte address is four times the index
	localparam logic [7:0] ADCC_IDX_RES_LO = 8'h78;
	localparam logic [7:0] ADCC_IDX_RES_HI = 8'h79;
	localparam logic [7:0] ADCC_IDX_CTRL   = 8'h7A;
	localparam logic [7:0] ADCC_IDX_TRIG   = 8'h7B;
	localparam logic [7:0] ADCC_IDX_MUX    = 8'h7C;

	localparam int ADCC_CS_EN_BIT    = 7;
	localparam int ADCC_CS_START_BIT = 6;
	localparam int ADCC_CS_ATE_BIT   = 5;
	localparam int ADCC_CS_DONE_BIT  = 4;
	localparam int ADCC_CS_DIE_BIT   = 3;
	localparam int ADCC_CS_DIV_LSB   = 0;
	localparam int ADCC_MX_REF_LSB   = 6;
	localparam int ADCC_MX_LEFT_BIT  = 5;
	localparam int ADCC_MX_CHAN_LSB  = 0;

	localparam logic [7:0] ADCC_CS_RST   = 8'h00;
	localparam logic [7:0] ADCC_MX_RST   = 8'h00;
	localparam logic [2:0] ADCC_TS_RST   = 3'h0;
	localparam logic [2:0] ADCC_TS_FREE  = 3'h0;

	localparam logic [4:0] ADCC_CONV_FIRST_CYC = 5'h19;
	localparam logic [4:0] ADCC_CONV_NORM_CYC  = 5'h0D;

	localparam logic [1:0] ADCC_REF_EXT  = 2'h0;
	localparam logic [1:0] ADCC_REF_AVCC = 2'h1;
	localparam logic [1:0] ADCC_REF_INT  = 2'h3;
	localparam logic [3:0] ADCC_CHAN_TEMP = 4'h8;
	localparam logic [3:0] ADCC_CHAN_BG   = 4'hE;
	localparam logic [3:0] ADCC_CHAN_GND  = 4'hF;

	typedef enum logic {ADCC_IDLE, ADCC_CONV} adcc_state_t;
endpackage

// ===== hdl/adcc_prescaler.sv
// Converter clock divider producing a one-cycle tick
`timescale 1ns/1ps
module adcc_prescaler import adcc_pkg::*; #(
	parameter int CNT_W = 7
) (
	input  wire logic             mclk,
	input  wire logic             rst_n,
	input  wire logic             en,
	input  wire logic [2:0]       div_sel,
	output logic                  tick
);
	logic [CNT_W-1:0] cnt_r;
	logic [2:0]       shift;
	logic [CNT_W-1:0] last;

	if (CNT_W < 7) begin : g_chk
		$error("adcc_prescaler: CNT_W must be at least 7");
	end

	// Codes 0 and 1 both divide by two
	assign shift = (div_sel == 3'h0) ? 3'h1 : div_sel;
	assign last  = CNT_W'((8'h01 << shift) - 8'h01);

	always_ff @(posedge mclk) begin
		if (!rst_n || !en) begin
			cnt_r <= '0;
			tick  <= 1'b0;
		end else if (cnt_r >= last) begin
			cnt_r <= '0;
			tick  <= 1'b1;
		end else begin
			cnt_r <= cnt_r + 1'b1;
			tick  <= 1'b0;
		end
	end
endmodule

// ===== hdl/adcc_ctrl.sv
// Converter control block with Avalon-MM register slave
//
// Decided for this implementation: the Avalon-MM slave port.
`timescale 1ns/1ps
module adcc_ctrl import adcc_pkg::*; #(
	parameter int ADDR_W = 8
) (
	input  wire logic              mclk,
	input  wire logic              rst_n,
	input  wire logic [ADDR_W-1:0] avs_address,
	input  wire logic              avs_read,
	input  wire logic              avs_write,
	input  wire logic [31:0]       avs_writedata,
	output logic [31:0]            avs_readdata,
	output logic                   avs_waitrequest,
	input  wire logic [7:1]        trig_src,
	input  wire logic              irq_ack,
	input  wire logic              global_irq_en,
	output logic                   irq,
	input  wire logic [9:0]        ana_result,
	output logic                   ana_power,
	output logic                   ana_convert,
	output logic                   ana_init,
	output logic                   ana_tick,
	output logic                   ana_ref_ext,
	output logic                   ana_ref_avcc,
	output logic                   ana_ref_int,
	output logic                   ana_chan_ext,
	output logic [2:0]             ana_chan_num,
	output logic                   ana_temp_sel,
	output logic                   ana_bandgap_sel,
	output logic                   ana_gnd_sel
);
	adcc_state_t state_r;
	logic        ack_r;
	logic [7:0]  rdata_r;
	logic        en_r;
	logic        ate_r;
	logic        done_r;
	logic        die_r;
	logic [2:0]  div_r;
	logic [1:0]  ref_r;
	logic        left_r;
	logic [3:0]  chan_r;
	logic [2:0]  ts_r;
	logic        first_r;
	logic [4:0]  len_r;
	logic [4:0]  cnt_r;
	logic [9:0]  result_r;
	logic        lock_r;
	logic [9:0]  res_s1_r;
	logic [9:0]  res_s2_r;
	logic        trig_prev_r;
	logic        tick;
	logic        bus_req;
	logic        wr_go;
	logic        rd_go;
	logic [7:0]  wd;
	logic        wr_cs;
	logic        wr_mx;
	logic        wr_ts;
	logic        en_eff;
	logic        busy;
	logic        conv_end;
	logic        trig_sel;
	logic        trig_edge;
	logic        auto_go;
	logic        go;
	logic [7:0]  res_lo;
	logic [7:0]  res_hi;
	logic [7:0]  cs_view;
	logic [7:0]  mx_view;
	logic [7:0]  rd_mux;

	if (ADDR_W < 8) begin : g_chk
		$error("adcc_ctrl: ADDR_W must be at least 8");
	end

	adcc_prescaler #(
		.CNT_W   (7)
	) u_presc (
		.mclk    (mclk),
		.rst_n   (rst_n),
		.en      (en_r),
		.div_sel (div_r),
		.tick    (tick)
	);

	// Each access waits exactly one cycle; effects happen at the releasing edge
	assign bus_req         = avs_read | avs_write;
	assign avs_waitrequest = bus_req & ~ack_r;
	assign wr_go           = avs_write & ack_r;
	assign rd_go           = avs_read & ack_r;
	assign wd              = avs_writedata[7:0];
	assign wr_cs           = wr_go && (avs_address == ADDR_W'(ADCC_IDX_CTRL));
	assign wr_mx           = wr_go && (avs_address == ADDR_W'(ADCC_IDX_MUX));
	assign wr_ts           = wr_go && (avs_address == ADDR_W'(ADCC_IDX_TRIG));
	assign avs_readdata    = {24'h000000, rdata_r};

	always_ff @(posedge mclk) begin
		if (!rst_n)
			ack_r <= 1'b0;
		else
			ack_r <= bus_req & ~ack_r;
	end

	// Alignment is applied at read time so a change shows at once
	assign res_hi = left_r ? result_r[9:2] : {6'h00, result_r[9:8]};
	assign res_lo = left_r ? {result_r[1:0], 6'h00} : result_r[7:0];
	assign busy    = (state_r == ADCC_CONV);
	assign cs_view = {en_r, busy, ate_r, done_r, die_r, div_r};
	assign mx_view = {ref_r, left_r, 1'b0, chan_r};

	always_comb begin
		rd_mux = 8'h00;
		if (avs_address == ADDR_W'(ADCC_IDX_RES_LO))
			rd_mux = res_lo;
		else if (avs_address == ADDR_W'(ADCC_IDX_RES_HI))
			rd_mux = res_hi;
		else if (avs_address == ADDR_W'(ADCC_IDX_CTRL))
			rd_mux = cs_view;
		else if (avs_address == ADDR_W'(ADCC_IDX_TRIG))
			rd_mux = {5'h00, ts_r};
		else if (avs_address == ADDR_W'(ADCC_IDX_MUX))
			rd_mux = mx_view;
	end

	always_ff @(posedge mclk) begin
		if (!rst_n)
			rdata_r <= 8'h00;
		else if (avs_read && !ack_r)
			rdata_r <= rd_mux;
	end

	// Software-written fields; the start and done bits are handled elsewhere
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			en_r  <= ADCC_CS_RST[ADCC_CS_EN_BIT];
			ate_r <= ADCC_CS_RST[ADCC_CS_ATE_BIT];
			die_r <= ADCC_CS_RST[ADCC_CS_DIE_BIT];
			div_r <= ADCC_CS_RST[ADCC_CS_DIV_LSB +: 3];
		end else if (wr_cs) begin
			en_r  <= wd[ADCC_CS_EN_BIT];
			ate_r <= wd[ADCC_CS_ATE_BIT];
			die_r <= wd[ADCC_CS_DIE_BIT];
			div_r <= wd[ADCC_CS_DIV_LSB +: 3];
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			ref_r  <= ADCC_MX_RST[ADCC_MX_REF_LSB +: 2];
			left_r <= ADCC_MX_RST[ADCC_MX_LEFT_BIT];
			chan_r <= ADCC_MX_RST[ADCC_MX_CHAN_LSB +: 4];
		end else if (wr_mx) begin
			ref_r  <= wd[ADCC_MX_REF_LSB +: 2];
			left_r <= wd[ADCC_MX_LEFT_BIT];
			chan_r <= wd[ADCC_MX_CHAN_LSB +: 4];
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n)
			ts_r <= ADCC_TS_RST;
		else if (wr_ts)
			ts_r <= wd[2:0];
	end

	// Selected source edge; source zero never yields an edge
	assign trig_sel  = (ts_r == ADCC_TS_FREE) ? 1'b0 : trig_src[ts_r];
	assign trig_edge = trig_sel & ~trig_prev_r;

	always_ff @(posedge mclk) begin
		if (!rst_n)
			trig_prev_r <= 1'b0;
		else
			trig_prev_r <= trig_sel;
	end

	// Free running restarts from the completion itself, not from the flag
	assign conv_end = busy && tick && (cnt_r == len_r - 5'h01);
	assign en_eff   = wr_cs ? wd[ADCC_CS_EN_BIT] : en_r;
	assign auto_go  = ate_r && (trig_edge || ((ts_r == ADCC_TS_FREE) && conv_end));
	assign go       = en_eff && (!busy || conv_end)
		&& ((wr_cs && wd[ADCC_CS_START_BIT]) || auto_go);

	always_ff @(posedge mclk) begin
		if (!rst_n)
			first_r <= 1'b1;
		else if (go)
			first_r <= 1'b0;
		else if (!en_r)
			first_r <= 1'b1;
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			state_r <= ADCC_IDLE;
			cnt_r   <= 5'h00;
			len_r   <= ADCC_CONV_NORM_CYC;
		end else if (wr_cs && !wd[ADCC_CS_EN_BIT]) begin
			state_r <= ADCC_IDLE;
			cnt_r   <= 5'h00;
		end else if (go) begin
			state_r <= ADCC_CONV;
			cnt_r   <= 5'h00;
			len_r   <= first_r ? ADCC_CONV_FIRST_CYC : ADCC_CONV_NORM_CYC;
		end else if (conv_end) begin
			state_r <= ADCC_IDLE;
			cnt_r   <= 5'h00;
		end else if (busy && tick) begin
			cnt_r   <= cnt_r + 5'h01;
		end
	end

	// Converter output comes from the analog domain
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			res_s1_r <= 10'h000;
			res_s2_r <= 10'h000;
		end else begin
			res_s1_r <= ana_result;
			res_s2_r <= res_s1_r;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n)
			result_r <= 10'h000;
		else if (conv_end && !lock_r)
			result_r <= res_s2_r;
	end

	// Result held between a low-byte read and the matching high-byte read
	always_ff @(posedge mclk) begin
		if (!rst_n)
			lock_r <= 1'b0;
		else if (rd_go && avs_address == ADDR_W'(ADCC_IDX_RES_LO))
			lock_r <= 1'b1;
		else if (rd_go && avs_address == ADDR_W'(ADCC_IDX_RES_HI))
			lock_r <= 1'b0;
	end

	// Completion wins over a clear in the same cycle
	always_ff @(posedge mclk) begin
		if (!rst_n)
			done_r <= 1'b0;
		else if (conv_end)
			done_r <= 1'b1;
		else if (irq_ack || (wr_cs && wd[ADCC_CS_DONE_BIT]))
			done_r <= 1'b0;
	end

	assign irq = done_r & die_r & global_irq_en;

	assign ana_power   = en_r;
	assign ana_convert = busy;
	assign ana_init    = busy && (len_r == ADCC_CONV_FIRST_CYC);
	assign ana_tick    = tick & busy;

	// Selections latch only at a start, so a running conversion keeps its own
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			ana_ref_ext     <= 1'b1;
			ana_ref_avcc    <= 1'b0;
			ana_ref_int     <= 1'b0;
			ana_chan_ext    <= 1'b1;
			ana_chan_num    <= 3'h0;
			ana_temp_sel    <= 1'b0;
			ana_bandgap_sel <= 1'b0;
			ana_gnd_sel     <= 1'b0;
		end else if (go) begin
			ana_ref_ext     <= (ref_r == ADCC_REF_EXT);
			ana_ref_avcc    <= (ref_r == ADCC_REF_AVCC);
			ana_ref_int     <= (ref_r == ADCC_REF_INT);
			ana_chan_ext    <= !chan_r[3];
			ana_chan_num    <= chan_r[2:0];
			ana_temp_sel    <= (chan_r == ADCC_CHAN_TEMP);
			ana_bandgap_sel <= (chan_r == ADCC_CHAN_BG);
			ana_gnd_sel     <= (chan_r == ADCC_CHAN_GND);
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	chk_done_sets: assert property (conv_end |=> done_r)
		else $error("done flag not set after completion");
	chk_done_clears: assert property (irq_ack && !conv_end |=> !done_r)
		else $error("done flag not cleared by vector ack");
	chk_busy_drops: assert property (conv_end && !go |=> !busy && !cs_view[ADCC_CS_START_BIT])
		else $error("start bit still high after completion");
	chk_disable_abort: assert property (wr_cs && !wd[ADCC_CS_EN_BIT] |=> !busy && !ana_power)
		else $error("disable did not abort conversion");
	chk_first_len: assert property (go && first_r |=> len_r == ADCC_CONV_FIRST_CYC)
		else $error("first conversion length wrong");
	chk_norm_len: assert property (go && !first_r |=> len_r == ADCC_CONV_NORM_CYC)
		else $error("normal conversion length wrong");
	chk_irq_raise: assert property ($rose(done_r) && die_r && global_irq_en |-> irq)
		else $error("interrupt not raised");
	chk_result_lock: assert property (lock_r && !rd_go |=> $stable(result_r))
		else $error("result changed while locked");
	chk_temp_route: assert property (go && chan_r == ADCC_CHAN_TEMP |=> ana_temp_sel && !ana_chan_ext)
		else $error("sensor not routed");
	chk_sel_hold: assert property (busy && !go |=> $stable(ana_chan_num) && $stable(ana_ref_int))
		else $error("selection changed during conversion");
	chk_mux_bit4: assert property (avs_read && !ack_r |=> !(rd_go && avs_address == ADDR_W'(ADCC_IDX_MUX))
		|| !avs_readdata[4])
		else $error("reserved bit read as one");
	chk_free_switch: assert property (ate_r && ts_r == ADCC_TS_FREE && !busy && !wr_cs |=> !busy)
		else $error("free running switch started conversion");

	// Bus timing, reset state, routing decode and start sources
	chk_wait_one: assert property (bus_req && avs_waitrequest |=> !avs_waitrequest || !bus_req)
		else $error("waitrequest held longer than one cycle");
	chk_reset_idle: assert property ($rose(rst_n) |-> !busy && !done_r && !en_r && !lock_r)
		else $error("control not idle after reset");
	chk_ref_int: assert property (go && ref_r == ADCC_REF_INT
		|=> ana_ref_int && !ana_ref_ext && !ana_ref_avcc)
		else $error("internal reference not selected");
	chk_ref_reserved: assert property (go && ref_r != ADCC_REF_EXT && ref_r != ADCC_REF_AVCC
		&& ref_r != ADCC_REF_INT |=> !ana_ref_ext && !ana_ref_avcc && !ana_ref_int)
		else $error("reserved reference code drove a reference");
	chk_chan_ext: assert property (go && !chan_r[3] |=> ana_chan_ext && ana_chan_num == $past(chan_r[2:0]))
		else $error("external channel not routed");
	chk_chan_gnd: assert property (go && chan_r == ADCC_CHAN_GND
		|=> ana_gnd_sel && !ana_temp_sel && !ana_bandgap_sel && !ana_chan_ext)
		else $error("ground input not routed");
	chk_left_apply: assert property (wr_mx |=> left_r == $past(wd[ADCC_MX_LEFT_BIT]))
		else $error("alignment bit not applied at once");
	chk_tick_stop: assert property (!en_r |=> !tick && !ana_tick)
		else $error("converter clock ticks while disabled");
	chk_init_first: assert property (go && first_r |=> ana_init)
		else $error("first conversion without initialisation");
	chk_start_zero: assert property (busy && wr_cs && wd[ADCC_CS_EN_BIT] && !wd[ADCC_CS_START_BIT]
		&& !conv_end |=> busy)
		else $error("writing zero to start stopped conversion");
	chk_trig_start: assert property (ate_r && en_r && trig_edge && !busy && !wr_cs |=> busy)
		else $error("trigger edge did not start conversion");
	chk_done_write: assert property (wr_cs && wd[ADCC_CS_DONE_BIT] && !conv_end |=> !done_r)
		else $error("done flag not cleared by writing one");
	chk_irq_drop: assert property (!done_r |-> !irq)
		else $error("interrupt without done flag");

	cov_first_done: cover property (go && first_r ##[1:1000] conv_end);
	cov_free_run: cover property (conv_end && go);
	cov_locked_end: cover property (conv_end && lock_r);
	cov_trig_start: cover property (trig_edge && ate_r && go);
	cov_abort: cover property (busy && wr_cs && !wd[ADCC_CS_EN_BIT]);
endmodule

// ===== tb/adcc_ana_model.sv
// Behavioural analog converter and input multiplexer facing the control block
`timescale 1ns/1ps
module adcc_ana_model (
	input  wire logic       mclk,
	input  wire logic       ana_convert,
	input  wire logic       ana_chan_ext,
	input  wire logic [2:0] ana_chan_num,
	input  wire logic       ana_temp_sel,
	input  wire logic       ana_bandgap_sel,
	input  wire logic       ana_gnd_sel,
	output logic [9:0]      ana_result
);
	initial ana_result = 10'h000;
	// Code names the routed input; outside a conversion it toggles so a stale capture shows
	always @(posedge mclk) begin
		if (ana_convert === 1'b1)
			ana_result <= {ana_temp_sel, ana_bandgap_sel, ana_gnd_sel, ana_chan_ext, 3'h3,
				ana_chan_ext ? ana_chan_num : 3'h0};
		else
			ana_result <= ~ana_result;
	end
endmodule

// ===== tb/tb.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
module tb import adcc_pkg::*;;
	typedef struct packed {logic [7:0] input_channel_select; logic [2:0] div; logic fresh;} adcc_row_t;
	logic        mclk = 1'b0;
	logic        rst_n, avs_read, avs_write, avs_waitrequest, irq_ack, global_irq_en, irq;
	logic [7:0]  avs_address;
	logic [31:0] avs_writedata, avs_readdata;
	logic [7:1]  trig_src;
	logic [9:0]  ana_result, v;
	logic        ana_power, ana_convert, ana_init, ana_tick, ana_ref_ext, ana_ref_avcc, ana_ref_int;
	logic        ana_chan_ext, ana_temp_sel, ana_bandgap_sel, ana_gnd_sel;
	logic [2:0]  ana_chan_num;
	int          nt, gap, lt, cyc, n_errors, total_checks, k;
	adcc_row_t   r;
	adcc_row_t   rows[8] = '{'{8'hC8, 3'h0, 1'b1}, '{8'h43, 3'h1, 1'b0}, '{8'h2E, 3'h2, 1'b0},
		'{8'h8F, 3'h3, 1'b1}, '{8'h7A, 3'h4, 1'b0}, '{8'h30, 3'h5, 1'b1}, '{8'h07, 3'h7, 1'b0},
		'{8'hD5, 3'h6, 1'b0}};

	adcc_ctrl adcc_ctrl_inst (.mclk(mclk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .trig_src(trig_src), .irq_ack(irq_ack),
		.global_irq_en(global_irq_en), .irq(irq), .ana_result(ana_result), .ana_power(ana_power),
		.ana_convert(ana_convert), .ana_init(ana_init), .ana_tick(ana_tick), .ana_ref_ext(ana_ref_ext),
		.ana_ref_avcc(ana_ref_avcc), .ana_ref_int(ana_ref_int), .ana_chan_ext(ana_chan_ext),
		.ana_chan_num(ana_chan_num), .ana_temp_sel(ana_temp_sel), .ana_bandgap_sel(ana_bandgap_sel),
		.ana_gnd_sel(ana_gnd_sel));
	adcc_ana_model adcc_ana_model_inst (.mclk(mclk), .ana_convert(ana_convert), .ana_chan_ext(ana_chan_ext),
		.ana_chan_num(ana_chan_num), .ana_temp_sel(ana_temp_sel), .ana_bandgap_sel(ana_bandgap_sel),
		.ana_gnd_sel(ana_gnd_sel), .ana_result(ana_result));

	always #10 mclk = ~mclk;
	// Tick count and spacing within conversions
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (ana_tick === 1'b1 && ana_convert === 1'b1) begin
			nt <= nt + 1;
			gap <= cyc - lt;
			lt <= cyc;
		end
	end

	function automatic logic [9:0] ev(input logic [3:0] c);
		return {c == 4'h8, c == 4'hE, c == 4'hF, c < 4'h8, 3'h3, c < 4'h8 ? c[2:0] : 3'h0};
	endfunction
	function automatic logic [9:0] rt();
		return {ana_temp_sel, ana_bandgap_sel, ana_gnd_sel, ana_chan_ext, 3'h3, ana_chan_ext ? ana_chan_num : 3'h0};
	endfunction
	function automatic logic [9:0] dv(input logic [2:0] s);
		return (s < 3'h2) ? 10'h002 : (10'h001 << s);
	endfunction
	function automatic logic [2:0] er(input logic [1:0] f);
		return (f == 2'h0) ? 3'h4 : (f == 2'h1) ? 3'h2 : (f == 2'h3) ? 3'h1 : 3'h0;
	endfunction

	task automatic chk(input string n, input logic [9:0] e, input logic [9:0] g);
		total_checks++;
		if (g !== e) begin
			n_errors++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask
	// Request stands until waitrequest is sampled low at a rising edge; data taken there
	task automatic bus(input logic rd, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
		int w;
		@(posedge mclk);
		avs_address <= a;
		avs_read <= rd;
		avs_write <= !rd;
		avs_writedata <= {24'h000000, d};
		w = 0;
		do begin
			@(posedge mclk);
			w++;
		end while (avs_waitrequest !== 1'b0 && w < 50);
		if (w >= 50)
			n_errors++;
		q = avs_readdata[7:0];
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] q;
		bus(1'b0, a, d, q);
	endtask
	task automatic rc(input string n, input logic [7:0] a, input logic [7:0] e);
		logic [7:0] q;
		bus(1'b1, a, 8'h00, q);
		chk(n, {2'h0, e}, {2'h0, q});
	endtask
	task automatic wc();
		k = 0;
		do begin
			@(negedge mclk);
			k++;
		end while (ana_convert !== 1'b0 && k < 5000);
		if (k >= 5000)
			n_errors++;
	endtask
	task automatic res(input logic l, input logic [9:0] x);
		rc("res_lo", 8'h78, l ? {x[1:0], 6'h00} : x[7:0]);
		rc("res_hi", 8'h79, l ? x[9:2] : {6'h00, x[9:8]});
	endtask
	task automatic stop_test();
		if (n_errors == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	initial begin
		repeat (40000) @(posedge mclk);
		n_errors++;
		stop_test();
	end

	initial begin
		{rst_n, avs_read, avs_write, irq_ack, avs_address, avs_writedata, trig_src} = '0;
		{nt, gap, lt, cyc, n_errors, total_checks} = '0;
		global_irq_en = 1'b1;
		repeat (5) @(posedge mclk);
		rst_n <= 1'b1;
		@(negedge mclk);
		chk("ref_ext", 10'h001, {9'h000, ana_ref_ext});
		for (int i = 0; i < 5; i++)
			rc("reset_reg", 8'h78 + 8'(i), 8'h00);
		rc("unmapped", 8'h00, 8'h00);
		foreach (rows[i]) begin
			r = rows[i];
			if (r.fresh)
				wr(8'h7A, 8'h00);
			wr(8'h7C, r.input_channel_select);
			rc("mux", 8'h7C, r.input_channel_select & 8'hEF);
			@(negedge mclk);
			nt = 0;
			wr(8'h7A, {5'h18, r.div});
			@(negedge mclk);
			chk("route", ev(r.input_channel_select[3:0]), rt());
			chk("init", {9'h000, r.fresh}, {9'h000, ana_init});
			chk("ref", {7'h00, er(r.input_channel_select[7:6])}, {7'h00, ana_ref_ext, ana_ref_avcc, ana_ref_int});
			rc("busy", 8'h7A, {5'h18, r.div});
			wc();
			chk("ticks", r.fresh ? 10'h019 : 10'h00D, nt[9:0]);
			chk("tick_gap", dv(r.div), gap[9:0]);
			rc("done", 8'h7A, {5'h12, r.div});
			res(r.input_channel_select[5], ev(r.input_channel_select[3:0]));
			wr(8'h7A, {5'h12, r.div});
		end
		chk("temp_c", 10'h099, 10'((32'(ev(4'h8)) - 32'h18A) * 32'h80 / 32'h8E + 32'h19));
		v = ev(4'h5);
		wr(8'h7C, 8'hF5);
		rc("left_hi", 8'h79, v[9:2]);
		wr(8'h7C, 8'h22);
		rc("lock_lo", 8'h78, {v[1:0], 6'h00});
		wr(8'h7A, 8'hC1);
		wr(8'h7C, 8'h2F);
		@(negedge mclk);
		chk("held", ev(4'h2), rt());
		wc();
		rc("lock_hi", 8'h79, v[9:2]);
		rc("done_locked", 8'h7A, 8'h91);
		wr(8'h7A, 8'hD1);
		@(negedge mclk);
		chk("applied", ev(4'hF), rt());
		wr(8'h7A, 8'h01);
		@(negedge mclk);
		chk("abort", 10'h000, {8'h00, ana_convert, ana_power});
		rc("abort_cs", 8'h7A, 8'h01);
		wr(8'h7A, 8'hC9);
		wr(8'h7A, 8'h89);
		@(negedge mclk);
		chk("start_zero", 10'h001, {9'h000, ana_convert});
		wc();
		chk("irq", 10'h001, {9'h000, irq});
		@(posedge mclk) global_irq_en <= 1'b0;
		@(negedge mclk);
		chk("irq_gie", 10'h000, {9'h000, irq});
		@(posedge mclk) global_irq_en <= 1'b1;
		irq_ack <= 1'b1;
		@(posedge mclk) irq_ack <= 1'b0;
		@(negedge mclk);
		chk("irq_ack", 10'h000, {9'h000, irq});
		rc("ack_cs", 8'h7A, 8'h89);
		wr(8'h7B, 8'h01);
		wr(8'h7A, 8'hA1);
		@(posedge mclk) trig_src <= 7'h01;
		repeat (3) @(negedge mclk);
		chk("trig", 10'h001, {9'h000, ana_convert});
		wc();
		repeat (4) @(negedge mclk);
		chk("one_edge", 10'h000, {9'h000, ana_convert});
		rc("trig_done", 8'h7A, 8'hB1);
		wr(8'h7B, 8'h00);
		repeat (4) @(negedge mclk);
		chk("free_switch", 10'h000, {9'h000, ana_convert});
		nt = 0;
		wr(8'h7A, 8'hF1);
		k = 0;
		while (nt < 20 && k < 500) begin
			@(negedge mclk);
			k++;
		end
		if (k >= 500)
			n_errors++;
		chk("free_run", 10'h001, {9'h000, ana_convert});
		@(posedge mclk) rst_n <= 1'b0;
		repeat (5) @(posedge mclk);
		rst_n <= 1'b1;
		@(negedge mclk);
		chk("rst_mid", 10'h001, {7'h00, ana_convert, ana_power, ana_ref_ext});
		rc("rst_cs", 8'h7A, 8'h00);
		rc("rst_mux", 8'h7C, 8'h00);
		wr(8'h7A, 8'h00);
		stop_test();
	end
endmodule
